/* File: bench/svar_assertions.sv */
`timescale 1ns/10ps
module svar_assertions (
	// clock and reset
	input wire        sys_clk,
	input wire        rst,
	// streams and store write strobe
	input wire        wr_start,
	input wire [15:0] wr_index,
	input wire        wr_valid,
	input wire        wr_last,
	input wire        wr_busy,
	input wire        wr_done,
	input wire        wr_error,
	input wire        rd_start,
	input wire        rd_busy,
	input wire        rd_valid_out,
	input wire        rd_last,
	input wire        rd_error,
	input wire        var_wr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	reg [15:0] idx_r;
	always @(posedge sys_clk)
		if (wr_start && !wr_busy && !rd_busy) idx_r <= wr_index;
	sequence s_last;
		wr_valid && wr_last && wr_busy && idx_r != 16'h0002;
	endsequence
	sequence s_end;
		wr_done || wr_error;
	endsequence
	write_end_a: assert property (s_last |=> s_end)
		else $error("write end");
	done_excl_a: assert property (!(wr_done && wr_error))
		else $error("done excl");
	done_pulse_a: assert property (wr_done |=> !wr_done)
		else $error("done pulse");
	start_busy_a: assert property (wr_start && !wr_busy && !rd_busy |=> wr_busy)
		else $error("start busy");
	last_valid_a: assert property (rd_last |-> rd_valid_out)
		else $error("last valid");
	read_ends_a: assert property (rd_last |=> !rd_valid_out)
		else $error("read ends");
	err_alone_a: assert property (rd_error |-> !rd_valid_out)
		else $error("err alone");
	read_quiet_a: assert property (rd_valid_out |-> !var_wr)
		else $error("read quiet");
	read_take_a: assert property (rd_start && !wr_start && !wr_busy && !rd_busy |=> rd_busy || rd_error)
		else $error("read take");
endmodule // svar_assertions
bind shared_variable_record_access svar_assertions i_svar_assertions (.*);

/* File: bench/svar_var_model.sv */
`timescale 1ns/10ps
module svar_var_model (
	// store port
	input  wire       sys_clk,
	input  wire       var_wr,
	input  wire [7:0] var_addr,
	input  wire [7:0] var_wdata,
	output wire [7:0] var_rdata
);
	reg [7:0] mem [0:255];
	always @(posedge sys_clk)
		if (var_wr) mem[var_addr] <= var_wdata;
	assign var_rdata = mem[var_addr];
endmodule // svar_var_model

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	reg sys_clk = 0, rst = 1, wr_start = 0, wr_valid = 0, wr_last = 0;
	reg rd_start = 0, d, e;
	reg [15:0] wr_index = 0;
	reg [7:0] wr_byte = 0, b [0:63], r [0:63];
	reg [63:0] hv;
	wire wr_busy, wr_done, wr_error, rd_busy, rd_valid_out, rd_last;
	wire rd_error, var_wr;
	wire [15:0] var_class, var_inst, var_attr;
	wire [7:0] rd_byte, var_addr, var_wdata, var_rdata;
	int errors = 0, total_checks = 0, n, len, k, i, cyc = 0;
	always #12.5 sys_clk = ~sys_clk;
	shared_variable_record_access i_shared_variable_record_access (.*);
	svar_var_model i_svar_var_model (.*);
	task chk(input [15:0] s, input [15:0] x);
		total_checks++;
		if (s !== x) begin
			errors++;
			$display("unexpected %0t got %h want %h", $time, s, x);
		end
	endtask
	task rec(input [15:0] x, input int m);
		@(negedge sys_clk) wr_start = 1;
		wr_index = x;
		@(negedge sys_clk) wr_start = 0;
		for (i = 0; i < m; i++) begin
			wr_valid = 1;
			wr_byte = b[i];
			wr_last = i == m - 1;
			@(negedge sys_clk);
		end
		wr_valid = 0;
		wr_last = 0;
		repeat (80) begin
			d = wr_done;
			e = wr_error;
			if (d | e) break;
			@(negedge sys_clk);
		end
	endtask
	task record_read_call;
		n = 0;
		e = 0;
		@(negedge sys_clk) rd_start = 1;
		@(negedge sys_clk) rd_start = 0;
		repeat (80) begin
			if (rd_valid_out) r[n++] = rd_byte;
			e = e | rd_error;
			if (rd_last | e) break;
			@(negedge sys_clk);
		end
	endtask
	// header byte, big-endian words
	function [7:0] hdr_byte(int j);
		hdr_byte = hv[63 - 8 * j -: 8];
	endfunction
	task complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 5000) begin
			errors++;
			complete_run;
		end
	end
	initial begin
		void'($urandom(32'hf6d1_5bd2));
		repeat (3) @(negedge sys_clk);
		rst = 0;
		record_read_call();
		chk(e, 1);
		for (k = 0; k < 4; k++) begin
			len = k ? 1 + $urandom % 8 : 44;
			hv = {$urandom, $urandom};
			hv[15:0] = len;
			for (i = 0; i < 8 + len; i++)
				b[i] = i < 8 ? hdr_byte(i) : 8'($urandom);
			rec(16'h0001, 8 + len);
			chk(d, 1);
			chk(var_class, hv[63:48]);
			chk(var_inst, hv[47:32]);
			chk(var_attr, hv[31:16]);
			rec(16'h0002, 8);
			chk(d, 1);
			record_read_call();
			chk(8'(n), 8'(8 + len));
			for (i = 0; i < n; i++)
				chk(r[i], b[i]);
		end
		rec(16'h0001, 5);
		chk(e, 1);
		complete_run;
	end
endmodule // tb_top

/* File: hw/shared_variable_record_access.v */
// Contract
// R1 - a variable write completes with one record write of header and value.
// R2 - a variable read is a record write naming the variable, then a record read.
// R3 - the controller compares the echoed class, instance and attribute.
// R4 - header words: class at 0, instance at 2, attribute at 4, length at 6, data from 8.
// R5 - the controller sets record length to 8 plus the data length.
// R6 - a record write with index 2 requests the selected variable's value.
// R7 - the terminal buffers the selected value until the matching record read.
// R8 - the controller waits on busy, then advances on done or sets -98 on error.
// R9 - the controller's write sequence ends by clearing its request bit.
// R10 - on read start the controller zeroes and fills the request block.
// R11 - on write start the controller fetches header fields, data already placed.
// R12 - a failed record read makes the controller set -99.
// R13 - the controller keeps at most one access in flight.
`timescale 1ns/10ps
`include "svar_defines.vh"
module shared_variable_record_access (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// record write byte stream
	input  wire        wr_start,
	input  wire [15:0] wr_index,
	input  wire        wr_valid,
	input  wire [7:0]  wr_byte,
	input  wire        wr_last,
	output wire        wr_busy,
	output reg         wr_done,
	output reg         wr_error,
	// record read byte stream
	input  wire        rd_start,
	output wire        rd_busy,
	output reg         rd_valid_out,
	output reg  [7:0]  rd_byte,
	output reg         rd_last,
	output reg         rd_error,
	// variable store access
	output reg         var_wr,
	output reg  [15:0] var_class,
	output reg  [15:0] var_inst,
	output reg  [15:0] var_attr,
	output reg  [7:0]  var_addr,
	output reg  [7:0]  var_wdata,
	input  wire [7:0]  var_rdata
);
	localparam S_IDLE = 3'd0;
	localparam S_RECV = 3'd1;
	localparam S_FILL = 3'd2;
	localparam S_SEND = 3'd4;

	reg [2:0]  state_r;
	reg [15:0] index_r;
	reg [7:0]  cnt_r;
	reg [15:0] len_r;
	reg [7:0]  hdr_r [0:7];
	reg [7:0]  echo_r [0:7];
	reg        pend_r;

	wire [7:0] buf_rd;
	reg        buf_we;
	reg  [5:0] buf_wa;
	reg  [7:0] buf_wd;
	wire [5:0] buf_ra;

	function [15:0] hword;
		input [7:0] hi;
		input [7:0] lo;
		hword = {hi, lo};
	endfunction

	// lengths beyond the buffer are clamped to it
	function [7:0] cap_len;
		input [15:0] len;
		if (len > {8'h00, `BUF_BYTES})
			cap_len = `BUF_BYTES;
		else
			cap_len = len[7:0];
	endfunction

	// byte 7 is still on the bus when wr_last comes with it
	wire [7:0]  len_lo  = (cnt_r == 8'h07) ? wr_byte : hdr_r[7];
	wire [15:0] len_req = {8'h00, cap_len(hword(hdr_r[6], len_lo))};

	// starts are taken only in idle
	assign wr_busy = (state_r == S_RECV) || (state_r == S_FILL);
	assign rd_busy = (state_r == S_SEND);
	// address one byte ahead: the store read is registered
	assign buf_ra = (cnt_r >= 8'h07) ? cnt_r[5:0] - 6'd7 : 6'd0;

	// R7 - value buffer
	svar_store u_store (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wr_en   (buf_we),
		.wr_addr (buf_wa),
		.wr_data (buf_wd),
		.rd_addr (buf_ra),
		.rd_data (buf_rd)
	);

	always @(posedge sys_clk) begin
		if (rst) begin
			state_r      <= S_IDLE;
			index_r      <= 16'h0000;
			cnt_r        <= 8'h00;
			len_r        <= 16'h0000;
			pend_r       <= 1'b0;
			wr_done      <= 1'b0;
			wr_error     <= 1'b0;
			rd_valid_out <= 1'b0;
			rd_byte      <= 8'h00;
			rd_last      <= 1'b0;
			rd_error     <= 1'b0;
			var_wr       <= 1'b0;
			var_class    <= 16'h0000;
			var_inst     <= 16'h0000;
			var_attr     <= 16'h0000;
			var_addr     <= 8'h00;
			var_wdata    <= 8'h00;
			buf_we       <= 1'b0;
			buf_wa       <= 6'd0;
			buf_wd       <= 8'h00;
		end else begin
			wr_done      <= 1'b0;
			wr_error     <= 1'b0;
			rd_valid_out <= 1'b0;
			rd_last      <= 1'b0;
			rd_error     <= 1'b0;
			var_wr       <= 1'b0;
			buf_we       <= 1'b0;
			case (state_r)
			S_IDLE: begin
				// a write start wins over a read start
				if (wr_start) begin
					index_r <= wr_index;
					cnt_r   <= 8'h00;
					state_r <= S_RECV;
				end else if (rd_start) begin
					// R12 - read without a pending request fails
					if (pend_r) begin
						cnt_r   <= 8'h00;
						state_r <= S_SEND;
					end else
						rd_error <= 1'b1;
				end
			end
			S_RECV: begin
				if (wr_valid) begin
					// R4 - header bytes then data
					if (cnt_r < `HDR_BYTES)
						hdr_r[cnt_r[2:0]] <= wr_byte;
					else if (index_r != `IDX_READ_REQ) begin
						// R1 - data goes straight to the variable
						var_wr    <= 1'b1;
						var_class <= hword(hdr_r[0], hdr_r[1]);
						var_inst  <= hword(hdr_r[2], hdr_r[3]);
						var_attr  <= hword(hdr_r[4], hdr_r[5]);
						var_addr  <= cnt_r - `HDR_BYTES;
						var_wdata <= wr_byte;
					end
					cnt_r <= cnt_r + 8'h01;
					if (wr_last) begin
						if (cnt_r < 8'h07) begin
							wr_error <= 1'b1;
							state_r  <= S_IDLE;
						end else if (index_r == `IDX_READ_REQ) begin
							// R6 - index 2 selects a read request
							var_class <= hword(hdr_r[0], hdr_r[1]);
							var_inst  <= hword(hdr_r[2], hdr_r[3]);
							var_attr  <= hword(hdr_r[4], hdr_r[5]);
							len_r     <= len_req;
							// R7 - keep header for echo
							echo_r[0] <= hdr_r[0];
							echo_r[1] <= hdr_r[1];
							echo_r[2] <= hdr_r[2];
							echo_r[3] <= hdr_r[3];
							echo_r[4] <= hdr_r[4];
							echo_r[5] <= hdr_r[5];
							echo_r[6] <= hdr_r[6];
							echo_r[7] <= len_lo;
							var_addr  <= 8'h00;
							cnt_r     <= 8'h00;
							state_r   <= S_FILL;
						end else begin
							wr_done <= 1'b1;
							state_r <= S_IDLE;
						end
					end
				end
			end
			S_FILL: begin
				// R7 - copy the selected variable into the buffer
				buf_we   <= 1'b1;
				buf_wa   <= cnt_r[5:0];
				buf_wd   <= var_rdata;
				cnt_r    <= cnt_r + 8'h01;
				var_addr <= var_addr + 8'h01;
				// length was clamped to the buffer when taken
				if (cnt_r + 8'h01 >= len_r[7:0]) begin
					pend_r  <= 1'b1;
					wr_done <= 1'b1;
					state_r <= S_IDLE;
				end
			end
			S_SEND: begin
				// R2 - echo header, then buffered value
				rd_valid_out <= 1'b1;
				// header bytes come from the copy kept at request time
				if (cnt_r < `HDR_BYTES)
					rd_byte <= echo_r[cnt_r[2:0]];
				else
					rd_byte <= buf_rd;
				cnt_r <= cnt_r + 8'h01;
				if (cnt_r + 8'h01 >= len_r[7:0] + `HDR_BYTES) begin
					rd_last <= 1'b1;
					pend_r  <= 1'b0;
					state_r <= S_IDLE;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // shared_variable_record_access

/* File: hw/svar_defines.vh */
`ifndef SVAR_DEFINES_VH
`define SVAR_DEFINES_VH

// request header byte offsets
`define HDR_CLASS_OFS      4'h0
`define HDR_INST_OFS       4'h2
`define HDR_ATTR_OFS       4'h4
`define HDR_LEN_OFS        4'h6
`define HDR_DATA_OFS       4'h8
`define HDR_BYTES          8'h08
// record indices
`define IDX_READ_REQ       16'h0002
// data buffer size in bytes (26 words)
`define BUF_BYTES          8'h34
`define BUF_AW             6

`endif

/* File: hw/svar_store.v */
`timescale 1ns/10ps
module svar_store (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// write side
	input  wire        wr_en,
	input  wire [5:0]  wr_addr,
	input  wire [7:0]  wr_data,
	// read side
	input  wire [5:0]  rd_addr,
	output reg  [7:0]  rd_data
);
	reg [7:0] mem [0:63];

	always @(posedge sys_clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always @(posedge sys_clk) begin
		if (rst)
			rd_data <= 8'h00;
		else
			rd_data <= mem[rd_addr];
	end
endmodule // svar_store
